// ### rtl/sdp_synth_top.sv
/*
 sdp_synth_top: divider and phase-comparison logic of the first LO, second LO
 and BFO synthesizer loops, with reference selection.
 assumes: every oscillator edge is presented as a one-cycle tick synchronous to
 clk_in, at most one tick per clock per input; the control processor holds the
 frequency settings steady between its updates.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - BFO reference path divides 1 MHz by fixed 2000, giving 500 Hz.
// - BFO variable ratio 44700..46300 comes from BCD inputs of the controller.
// - BFO oscillator feeds fixed divide-by-50 output and the programmable feedback divider.
// - BFO comparator at 500 Hz compares variable divider against divided reference.
// - after divide by 50, BFO output moves in 10 Hz steps over 447..463 kHz.
// - second-LO chain divides the 20 MHz oscillator by 20, 4 or 2.
// - both links 1 MHz, second link only 5 MHz, first link only 10 MHz.
// - second-LO divided output and selected reference go to a digital comparator.
// - select grounded uses internal oscillator; released powers it down, uses external.
// - first-LO N comes from frequency inputs; divided VCO compared against reference.
// - each unit step of N shifts first-LO output by one reference interval.
// - first-LO covers 40.605 to 70.455 MHz in 10 Hz steps.
// - steps below the 100 kHz reference alter N only briefly.
// - after one full cycle of phase gain, one VCO cycle is swallowed.
module sdp_synth_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic bfo_vco_tick_in,
  input wire logic ref_1m_tick_in,
  input wire logic [4*sdp_pkg::BCD_DIGITS-1:0] bfo_ratio_bcd_in,
  input wire logic lo2_osc_tick_in,
  input wire logic ratio_link_a_in,
  input wire logic ratio_link_b_in,
  input wire logic int_ref_sel_n_in,
  input wire logic int_ref_tick_in,
  input wire logic ext_ref_tick_in,
  input wire logic lo1_vco_tick_in,
  input wire logic lo1_ref_tick_in,
  input wire logic [sdp_pkg::DW-1:0] lo1_n_in,
  input wire logic [sdp_pkg::FW-1:0] lo1_frac_in,
  output logic bfo_out,
  output logic ext_ref_out,
  output logic int_osc_en_out,
  output logic ext_in_en_out,
  output logic [sdp_pkg::NPFD-1:0] pfd_up_out,
  output logic [sdp_pkg::NPFD-1:0] pfd_dn_out
);
  import sdp_pkg::*;

  function automatic logic [DW-1:0] bcd_to_bin(input logic [4*BCD_DIGITS-1:0] b);
    logic [DW+3:0] acc;
    acc = '0;
    for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
      acc = (DW+4)'(acc * 10) + (DW+4)'(b[4*d +: 4]);
    end
    return acc[DW-1:0];
  endfunction : bcd_to_bin

  function automatic logic bcd_ok(input logic [4*BCD_DIGITS-1:0] b);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < BCD_DIGITS; d++) begin
      if (b[4*d +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : bcd_ok

  sdp_div_if #(.W(DW)) dif [NDIV] ();

  // ratio and settings state
  logic [DW-1:0] bfo_n_r, bfo_n_nxt;
  logic [DW-1:0] lo2_div_r, lo2_div_nxt;
  logic [DW-1:0] lo1_n_r, lo1_n_nxt;
  logic int_sel_r, int_sel_nxt;
  logic [DW-1:0] bcd_val;

  assign bcd_val = bcd_to_bin(bfo_ratio_bcd_in);

  always_comb begin
    bfo_n_nxt = bfo_n_r;
    // out-of-range or malformed codes keep the last good ratio
    if (bcd_ok(bfo_ratio_bcd_in) && bcd_val >= BFO_N_MIN && bcd_val <= BFO_N_MAX) begin
      bfo_n_nxt = bcd_val;
    end
    // no link fitted is not a documented option; treat it as 1 MHz
    unique case ({ratio_link_a_in, ratio_link_b_in})
      2'b01: lo2_div_nxt = DIV_LO2_5M;
      2'b10: lo2_div_nxt = DIV_LO2_10M;
      default: lo2_div_nxt = DIV_LO2_1M;
    endcase
    lo1_n_nxt = lo1_n_in;
    int_sel_nxt = !int_ref_sel_n_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bfo_n_r <= BFO_N_RST;
      lo2_div_r <= DIV_LO2_1M;
      lo1_n_r <= LO1_N_RST;
      int_sel_r <= 1'b1;
    end else begin
      bfo_n_r <= bfo_n_nxt;
      lo2_div_r <= lo2_div_nxt;
      lo1_n_r <= lo1_n_nxt;
      int_sel_r <= int_sel_nxt;
    end
  end

  // first-LO fractional steps by cycle absorption
  logic [FW-1:0] frac_acc_r, frac_acc_nxt;
  logic swal_r, swal_nxt;
  logic [FW:0] frac_sum;

  // one fraction unit is one fine step of a reference interval
  assign frac_sum = {1'b0, frac_acc_r} + {1'b0, lo1_frac_in};

  always_comb begin
    frac_acc_nxt = frac_acc_r;
    swal_nxt = swal_r;
    // a pending swallow is consumed by the next vco tick
    if (lo1_vco_tick_in) swal_nxt = 1'b0;
    // phase gained per reference period; a whole cycle means one swallow
    if (lo1_ref_tick_in) begin
      if (frac_sum >= {1'b0, FRAC_MOD}) begin
        frac_acc_nxt = FW'(frac_sum - {1'b0, FRAC_MOD});
        swal_nxt = 1'b1;
      end else begin
        frac_acc_nxt = frac_sum[FW-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frac_acc_r <= '0;
      swal_r <= 1'b0;
    end else begin
      frac_acc_r <= frac_acc_nxt;
      swal_r <= swal_nxt;
    end
  end

  logic ref_sel_tick;
  assign ref_sel_tick = int_sel_r ? int_ref_tick_in : ext_ref_tick_in;

  // divider wiring: the BFO vco drives the output and variable dividers, the 1 MHz tick the reference divider
  assign dif[IX_BFO_OUT].tick = bfo_vco_tick_in;
  assign dif[IX_BFO_OUT].ratio = DIV_BFO_OUT;
  assign dif[IX_BFO_VAR].tick = bfo_vco_tick_in;
  assign dif[IX_BFO_VAR].ratio = bfo_n_r;
  assign dif[IX_BFO_REF].tick = ref_1m_tick_in;
  assign dif[IX_BFO_REF].ratio = DIV_BFO_REF;
  assign dif[IX_LO2].tick = lo2_osc_tick_in;
  assign dif[IX_LO2].ratio = lo2_div_r;
  assign dif[IX_LO1].tick = lo1_vco_tick_in;
  assign dif[IX_LO1].ratio = lo1_n_r;
  assign dif[IX_BFO_OUT].swallow = 1'b0;
  assign dif[IX_BFO_VAR].swallow = 1'b0;
  assign dif[IX_BFO_REF].swallow = 1'b0;
  assign dif[IX_LO2].swallow = 1'b0;
  assign dif[IX_LO1].swallow = swal_r;

  for (genvar g = 0; g < NDIV; g++) begin : g_div
    sdp_prog_div #(.W(DW)) u_div (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .bus(dif[g])
    );
  end

  // phase-frequency comparators: 0 BFO, 1 second LO, 2 first LO
  logic [NPFD-1:0] pfd_a, pfd_b;
  logic [NPFD-1:0] up_r, up_nxt, dn_r, dn_nxt;
  assign pfd_a = {dif[IX_LO1].tc, dif[IX_LO2].tc, dif[IX_BFO_VAR].tc};
  assign pfd_b = {lo1_ref_tick_in, ref_sel_tick, dif[IX_BFO_REF].tc};

  always_comb begin
    for (int p = 0; p < NPFD; p++) begin
      up_nxt[p] = up_r[p] | pfd_a[p];
      dn_nxt[p] = dn_r[p] | pfd_b[p];
      // both edges seen: phase error resolved, clear both
      if (up_nxt[p] && dn_nxt[p]) begin
        up_nxt[p] = 1'b0;
        dn_nxt[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_r <= '0;
      dn_r <= '0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bfo_out <= 1'b0;
      ext_ref_out <= 1'b0;
      int_osc_en_out <= 1'b1;
      ext_in_en_out <= 1'b0;
    end else begin
      bfo_out <= dif[IX_BFO_OUT].tc;
      ext_ref_out <= dif[IX_LO2].tc;
      int_osc_en_out <= int_sel_r;
      ext_in_en_out <= !int_sel_r;
    end
  end
  assign pfd_up_out = up_r;
  assign pfd_dn_out = dn_r;

  // assertion helpers: ticks counted between terminal pulses
  logic [DW-1:0] ref_cnt_h, out_cnt_h;
  logic ref_seen_h, out_seen_h;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_cnt_h <= '0;
      out_cnt_h <= '0;
      ref_seen_h <= 1'b0;
      out_seen_h <= 1'b0;
    end else begin
      if (dif[IX_BFO_REF].tc) begin
        ref_cnt_h <= DW'(ref_1m_tick_in);
        ref_seen_h <= 1'b1;
      end else if (ref_1m_tick_in) begin
        ref_cnt_h <= ref_cnt_h + DW'(1);
      end
      if (dif[IX_BFO_OUT].tc) begin
        out_cnt_h <= DW'(bfo_vco_tick_in);
        out_seen_h <= 1'b1;
      end else if (bfo_vco_tick_in) begin
        out_cnt_h <= out_cnt_h + DW'(1);
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_ref_div_count: assert property (
    dif[IX_BFO_REF].tc && ref_seen_h |-> ref_cnt_h == DIV_BFO_REF)
    else $error("reference divider period is not 2000 ticks");
  a_out_div_count: assert property (
    dif[IX_BFO_OUT].tc && out_seen_h |-> out_cnt_h == DIV_BFO_OUT)
    else $error("bfo output divider period is not 50 ticks");
  a_bfo_ratio_range: assert property (
    bfo_n_r >= BFO_N_MIN && bfo_n_r <= BFO_N_MAX)
    else $error("bfo ratio left its range");
  a_pfd_never_both: assert property (
    !(pfd_up_out[0] && pfd_dn_out[0]) && !(pfd_up_out[1] && pfd_dn_out[1]))
    else $error("comparator drove up and down together");
  a_lo2_link_map: assert property (
    !ratio_link_a_in && ratio_link_b_in |=> lo2_div_r == DIV_LO2_5M)
    else $error("second link alone did not select divide by 4");
  a_int_ref_path: assert property (
    !int_ref_sel_n_in |=> ##1 int_osc_en_out && !ext_in_en_out)
    else $error("grounded select did not pick internal reference");
  a_frac_bounded: assert property (
    frac_acc_r < FRAC_MOD)
    else $error("phase accumulator exceeded one cycle");
  a_swallow_set: assert property (
    lo1_ref_tick_in && frac_sum >= {1'b0, FRAC_MOD} |=> swal_r)
    else $error("full cycle gained but no swallow pending");
  a_swallow_freeze: assert property (
    swal_r && lo1_vco_tick_in |=> $stable(g_div[IX_LO1].u_div.cnt_r) && !swal_r)
    else $error("swallowed tick still advanced the divider");

  c_bfo_lock: cover property (pfd_up_out[0] ##[1:20] pfd_dn_out[0]);
  c_swallow: cover property (swal_r && lo1_vco_tick_in);
  c_ext_ref: cover property (int_ref_sel_n_in ##2 ext_in_en_out);
endmodule : sdp_synth_top

// ### rtl/sdp_pkg.sv
/*
 sdp_pkg: constants shared by the synthesizer divider and phase logic.
 assumes: one 100 MHz system clock; all oscillator edges arrive as one-cycle ticks.
*/
package sdp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int DW = 17;
  localparam int BCD_DIGITS = 5;
  localparam logic [DW-1:0] DIV_BFO_OUT = 17'h0_0032;
  localparam logic [DW-1:0] DIV_BFO_REF = 17'h0_07D0;
  localparam logic [DW-1:0] BFO_N_MIN = 17'h0_AE9C;
  localparam logic [DW-1:0] BFO_N_MAX = 17'h0_B4DC;
  localparam logic [DW-1:0] BFO_N_RST = 17'h0_B1BC;
  localparam logic [DW-1:0] DIV_LO2_1M = 17'h0_0014;
  localparam logic [DW-1:0] DIV_LO2_5M = 17'h0_0004;
  localparam logic [DW-1:0] DIV_LO2_10M = 17'h0_0002;
  localparam logic [DW-1:0] LO1_N_RST = 17'h0_0196;
  localparam int LO1_REF_HZ = 100_000;
  localparam int LO1_STEP_HZ = 10;
  localparam int FW = 14;
  localparam logic [FW-1:0] FRAC_MOD = FW'(LO1_REF_HZ / LO1_STEP_HZ);
  localparam int NDIV = 5;
  localparam int IX_BFO_OUT = 0;
  localparam int IX_BFO_VAR = 1;
  localparam int IX_BFO_REF = 2;
  localparam int IX_LO2 = 3;
  localparam int IX_LO1 = 4;
  localparam int NPFD = 3;
endpackage : sdp_pkg

// ### rtl/sdp_div_if.sv
/*
 sdp_div_if: carries ratio, input tick, swallow request and terminal-count pulse
 between the control logic and one programmable divider.
 assumes: all signals synchronous to the system clock.
*/
`timescale 1ns/100ps
interface sdp_div_if #(parameter int W = 17);
  logic tick;
  logic swallow;
  logic [W-1:0] ratio;
  logic tc;
  modport ctl (output tick, output swallow, output ratio, input tc);
  modport div (input tick, input swallow, input ratio, output tc);
endinterface : sdp_div_if

// ### rtl/sdp_prog_div.sv
/*
 sdp_prog_div: down-counting divider, one tc pulse per ratio input ticks.
 assumes: ratio >= 2; tick is a one-cycle enable; swallow absorbs a tick.
*/
`timescale 1ns/100ps
module sdp_prog_div #(
  parameter int W = 17
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sdp_div_if.div bus
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic tc_r, tc_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tc_nxt = 1'b0;
    // an absorbed tick leaves the count alone, slipping one input cycle
    if (bus.tick && !bus.swallow) begin
      if (cnt_r == '0) begin
        // reload only at terminal count, so a new ratio never cuts a cycle short
        cnt_nxt = bus.ratio - W'(1);
        tc_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
      tc_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tc_r <= tc_nxt;
    end
  end

  assign bus.tc = tc_r;
endmodule : sdp_prog_div

// ### sim/sdp_ctl_model.sv
/*
 sdp_ctl_model: stands in for the control processor that feeds frequency settings.
 assumes: the bench asks for a setting; it is presented at the next falling edge.
*/
`timescale 1ns/100ps
module sdp_ctl_model (
  input wire logic clk_in,
  input wire logic [4*sdp_pkg::BCD_DIGITS-1:0] bcd_in,
  input wire logic [1:0] links_in,
  input wire logic sel_n_in,
  input wire logic [sdp_pkg::DW-1:0] n_in,
  input wire logic [sdp_pkg::FW-1:0] frac_in,
  output logic [4*sdp_pkg::BCD_DIGITS-1:0] bcd_out,
  output logic [1:0] links_out,
  output logic sel_n_out,
  output logic [sdp_pkg::DW-1:0] n_out,
  output logic [sdp_pkg::FW-1:0] frac_out
);
  import sdp_pkg::*;
  initial {bcd_out, links_out, sel_n_out, n_out, frac_out} = '0;
  // a change is sent whole in one edge, never digit by digit
  always @(negedge clk_in) begin
    bcd_out <= bcd_in;
    links_out <= links_in;
    sel_n_out <= sel_n_in;
    n_out <= n_in;
    frac_out <= frac_in;
  end
endmodule : sdp_ctl_model

// ### sim/tb.sv
/*
 tb: scenario tasks for the synthesizer divider and phase logic.
 assumes: ticks and settings change at falling edges; outputs sampled there too.
*/
`timescale 1ns/100ps
module tb;
  import sdp_pkg::*;
  logic clk_in = 0, nrst_in = 0, s_sel = 0, bfo_out, ext_ref_out, int_osc_en_out, ext_in_en_out;
  logic [6:0] g = '0, os = '0;
  logic [19:0] s_bcd = 20'h4_5500, bcd;
  logic [1:0] s_lk = 2'h3, lk;
  logic sel_n;
  logic [16:0] s_n = 17'h0_000A, n;
  logic [13:0] s_fr = 14'h0000, fr;
  logic [2:0] pfd_up_out, pfd_dn_out;
  int p [7] = '{default: 0};
  int cyc = 0, n_fail = 0, checked = 0;
  initial forever #5 clk_in = ~clk_in;
  // ticks: 0 bfo vco, 1 ref 1m, 2 lo2, 3 int ref, 4 ext ref, 5 lo1 vco, 6 lo1 ref
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 7; i++) g[i] <= (p[i] != 0) && (cyc % p[i] == 0);
  end
  sdp_ctl_model ctl (.clk_in(clk_in), .bcd_in(s_bcd), .links_in(s_lk), .sel_n_in(s_sel),
    .n_in(s_n), .frac_in(s_fr), .bcd_out(bcd), .links_out(lk), .sel_n_out(sel_n),
    .n_out(n), .frac_out(fr));
  sdp_synth_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .bfo_vco_tick_in(g[0] | os[0]),
    .ref_1m_tick_in(g[1] | os[1]), .bfo_ratio_bcd_in(bcd), .lo2_osc_tick_in(g[2] | os[2]),
    .ratio_link_a_in(lk[1]), .ratio_link_b_in(lk[0]), .int_ref_sel_n_in(sel_n),
    .int_ref_tick_in(g[3] | os[3]), .ext_ref_tick_in(g[4] | os[4]),
    .lo1_vco_tick_in(g[5] | os[5]), .lo1_ref_tick_in(g[6] | os[6]), .lo1_n_in(n),
    .lo1_frac_in(fr), .bfo_out(bfo_out), .ext_ref_out(ext_ref_out),
    .int_osc_en_out(int_osc_en_out), .ext_in_en_out(ext_in_en_out),
    .pfd_up_out(pfd_up_out), .pfd_dn_out(pfd_dn_out));
  task final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  task rst;
    p <= '{default: 0};
    nrst_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(negedge clk_in);
  endtask : rst
  task pulse(input int c);
    @(negedge clk_in) os[c] <= 1'b1;
    @(negedge clk_in) os[c] <= 1'b0;
    repeat (3) @(negedge clk_in);
  endtask : pulse
  function automatic logic sig(input int k);
    return k == 0 ? bfo_out : k == 1 ? ext_ref_out : pfd_dn_out[0];
  endfunction : sig
  // bounded wait for an output level; t is the cycle count when it is seen
  task wait_lvl(input int k, input logic v, output int t);
    int w;
    w = 0;
    do begin
      @(negedge clk_in);
      w++;
    end while (sig(k) !== v && w < 50000);
    if (w >= 50000) chk(0, 1);
    t = cyc;
  endtask : wait_lvl
  task period(input int k, output int d);
    int t0, t1;
    wait_lvl(k, 1'b0, t0);
    wait_lvl(k, 1'b1, t0);
    wait_lvl(k, 1'b0, t1);
    wait_lvl(k, 1'b1, t1);
    d = t1 - t0;
  endtask : period
  task t_bfo_out;
    int d;
    rst();
    p[0] <= 1;
    period(0, d);
    chk(d, DIV_BFO_OUT);
  endtask : t_bfo_out
  task t_links;
    int d;
    logic [1:0] lks [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    int exp [4] = '{20, 4, 2, 20};
    rst();
    p[2] <= 1;
    for (int i = 0; i < 4; i++) begin
      s_lk <= lks[i];
      period(1, d);
      period(1, d); // first period may still run on the old ratio
      chk(d, exp[i]);
    end
  endtask : t_links
  task t_sel;
    rst();
    chk({int_osc_en_out, ext_in_en_out, pfd_up_out}, 5'h10);
    pulse(3);
    chk({pfd_dn_out[1], pfd_up_out[1]}, 2'h2);
    pulse(2);
    chk({pfd_dn_out[1], pfd_up_out[1]}, 2'h0);
    s_sel <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk({int_osc_en_out, ext_in_en_out}, 2'h1);
    pulse(3);
    chk(pfd_dn_out[1], 1'b0);
    pulse(4);
    chk(pfd_dn_out[1], 1'b1);
    s_sel <= 1'b0;
  endtask : t_sel
  task t_bfo_pfd;
    int tr, tf, tr2;
    rst();
    s_bcd <= 20'h4_4700;
    repeat (3) @(negedge clk_in);
    s_bcd <= 20'h4_6301; // out of range: must be ignored
    repeat (3) @(negedge clk_in);
    p[0] <= 1;
    p[1] <= 1;
    wait_lvl(2, 1'b1, tr);
    wait_lvl(2, 1'b0, tf);
    wait_lvl(2, 1'b1, tr2);
    chk(tf - tr, 44700 - 2000);
    chk(tr2 - tf, 2000 * 23 - 44700);
  endtask : t_bfo_pfd
  // locked loop: comparator pulse widths must not drift over the run
  task lo1_run(input logic [16:0] nv, input logic [13:0] fv, input int pr);
    int w, w0, wl;
    rst();
    s_n <= nv;
    s_fr <= fv;
    repeat (4) @(negedge clk_in);
    p[5] <= 2;
    p[6] <= pr;
    w = 0;
    w0 = 0;
    wl = 0;
    for (int i = 0; i < 40 * pr; i++) begin
      @(negedge clk_in);
      if ((pfd_up_out[2] | pfd_dn_out[2]) === 1'b1) w++;
      else if (w > 0) begin
        if (i < 8 * pr) w0 = w;
        wl = w;
        w = 0;
      end
    end
    chk(wl <= w0 + 3 && w0 <= wl + 3, 1'b1);
  endtask : lo1_run
  initial begin
    #1_000_000;
    n_fail++;
    final_report();
  end
  initial begin
    t_sel();
    t_bfo_out();
    t_links();
    lo1_run(17'h0_000A, 14'h1388, 21);
    lo1_run(17'h0_000B, 14'h0000, 22);
    t_bfo_pfd();
    final_report();
  end
endmodule : tb
